// file: include/ctsw_pkg.sv
`default_nettype none
package ctsw_pkg;
    // ----------------------------------------------------------------
    // Register port and word indices
    // ----------------------------------------------------------------
    localparam int          DW             = 32;
    localparam int          AW             = 6;
    localparam logic [5:0]  ADR_CTICK_CTRL = 6'h00;
    localparam logic [5:0]  ADR_CTICK_CNT  = 6'h01;
    localparam logic [5:0]  ADR_FTICK      = 6'h02;
    localparam logic [5:0]  ADR_PLL        = 6'h03;
    localparam logic [5:0]  ADR_DBL        = 6'h04;
    localparam logic [5:0]  ADR_MAIN_OSC   = 6'h05;
    localparam logic [5:0]  ADR_DIV_BASE   = 6'h08;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CT_CLR_BIT   = 0;
    localparam int CT_INTEN_BIT = 1;
    localparam int CT_WAKE_BIT  = 2;
    localparam int CT_TAP_LSB   = 4;
    localparam int FT_INTEN_BIT = 8;
    localparam int FT_CNT_LSB   = 16;
    localparam int PLL_LOCK_BIT = 16;
    localparam int DBL_RDY_BIT  = 3;
    localparam int MO_USB_BIT   = 3;
    localparam int MO_TRIM_LSB  = 8;
    localparam int DIV_SRC_LSB  = 16;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_DIV   = 14;
    localparam int BUS_IDX   = 12;
    localparam int CPU_IDX   = 13;
    localparam int CPU_DIV_W = 4;
    localparam int DIV_W     = 16;
    localparam int CTICK_W   = 13;
    localparam int FTICK_W   = 5;
    localparam int NUM_FREQ  = 6;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS        = 8;
    localparam int LS_HALF_NS    = 5000;
    localparam int LS_HALF_CYC   = LS_HALF_NS / CLK_NS;
    localparam int THIRD_HALVES  = 3;
    localparam int SLOW_HALVES   = 100;
    localparam int PLL_LOCK_NS   = 250000;
    localparam int PLL_LOCK_CYC  = PLL_LOCK_NS / CLK_NS;
    localparam int DBL_START_NS  = 1000;
    localparam int DBL_START_CYC = DBL_START_NS / CLK_NS;
    localparam int WATCH_DIV     = 32768;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  CT_TAP_RST    = 4'h0;
    localparam logic [4:0]  FT_TC_RST     = 5'h1F;
    localparam logic [2:0]  MO_FREQ_RST   = 3'h0;
    localparam logic [15:0] DIV_RATIO_RST = 16'h0001;
    // Factory trims per frequency step; values are arbitrary
    localparam logic [7:0] MAIN_TRIM [NUM_FREQ] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94};

    typedef enum logic [1:0] {
        PLL_OFF    = 2'b00,
        PLL_ACQ    = 2'b01,
        PLL_LOCKED = 2'b10
    } ctsw_pll_state_type;

    typedef struct packed {
        logic        en;
        logic [1:0]  ref_sel;
        logic [5:0]  fb_div;
        logic [5:0]  in_div;
    } ctsw_pll_cfg_type;

    typedef struct packed {
        logic [2:0]  src;
        logic [15:0] ratio;
    } ctsw_div_cfg_type;
endpackage
`default_nettype wire

// file: rtl/ctsw_top.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ctsw_top #(
    parameter int PLL_LOCK_CYC = ctsw_pkg::PLL_LOCK_CYC,
    parameter int LS_HALF_CYC  = ctsw_pkg::LS_HALF_CYC
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        srst_i,
    input  wire logic [ctsw_pkg::AW-1:0]     addr_i,
    input  wire logic [ctsw_pkg::DW-1:0]     wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [ctsw_pkg::DW-1:0]     rdata_o,
    input  wire logic                        hibernate_i,
    input  wire logic                        debug_halt_i,
    input  wire logic [7:0]                  src_tick_i,
    input  wire logic                        usb_trim_up_i,
    input  wire logic                        usb_trim_dn_i,
    input  wire logic                        watch_tick_i,
    output logic                             slow_tick_clock_o,
    output logic                             third_rate_clock_o,
    output logic                             low_power_master_clock_o,
    output logic                             ctick_int_o,
    output logic                             ctick_wake_o,
    output logic                             ftick_int_o,
    output ctsw_pkg::ctsw_pll_cfg_type       pll_cfg_o,
    output logic                             pll_lock_o,
    output logic                             pll_out_valid_o,
    output logic                             dbl_en_o,
    output logic      [1:0]                  dbl_src_o,
    output logic                             dbl_ready_o,
    output logic      [2:0]                  main_osc_freq_o,
    output logic      [7:0]                  main_osc_trim_o,
    output logic                             sleep_tick_o,
    output logic                             rtc_sec_o,
    output logic      [ctsw_pkg::NUM_DIV-1:0] div_clk_o
);
    localparam int PW = $clog2(LS_HALF_CYC + 1);
    localparam int LW = $clog2(PLL_LOCK_CYC + 1);
    localparam int CW = ctsw_pkg::CTICK_W;
    localparam int FW = ctsw_pkg::FTICK_W;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire logic wr_ct  = wr_i && (addr_i == ctsw_pkg::ADR_CTICK_CTRL);
    wire logic wr_ft  = wr_i && (addr_i == ctsw_pkg::ADR_FTICK);
    wire logic wr_pll = wr_i && (addr_i == ctsw_pkg::ADR_PLL);
    wire logic wr_dbl = wr_i && (addr_i == ctsw_pkg::ADR_DBL);
    wire logic wr_mo  = wr_i && (addr_i == ctsw_pkg::ADR_MAIN_OSC);

    // ----------------------------------------------------------------
    // Low-speed oscillator taps
    // ----------------------------------------------------------------
    logic [PW-1:0] pre_reg;
    logic [1:0]    third_cnt_reg;
    logic [6:0]    slow_cnt_reg;
    logic          lp_clk_reg;
    logic          third_clk_reg;
    logic          slow_clk_reg;

    wire logic half_tick = (pre_reg == PW'(LS_HALF_CYC - 1));
    wire logic tick_100k = half_tick && !lp_clk_reg;
    wire logic third_wrap = half_tick && (third_cnt_reg == 2'(ctsw_pkg::THIRD_HALVES - 1));
    wire logic slow_wrap = half_tick && (slow_cnt_reg == 7'(ctsw_pkg::SLOW_HALVES - 1));
    wire logic tick_1k = slow_wrap && !slow_clk_reg;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pre_reg       <= '0;
            third_cnt_reg <= 2'h0;
            slow_cnt_reg  <= 7'h00;
            lp_clk_reg    <= 1'b0;
            third_clk_reg <= 1'b0;
            slow_clk_reg  <= 1'b0;
        end else begin
            pre_reg <= half_tick ? '0 : pre_reg + PW'(1);
            if (half_tick) begin
                lp_clk_reg    <= !lp_clk_reg;
                third_cnt_reg <= third_wrap ? 2'h0 : third_cnt_reg + 2'h1;
                slow_cnt_reg  <= slow_wrap ? 7'h00 : slow_cnt_reg + 7'h01;
            end
            // Toggle every third half period: 33 kHz at even duty
            if (third_wrap) begin
                third_clk_reg <= !third_clk_reg;
            end
            if (slow_wrap) begin
                slow_clk_reg <= !slow_clk_reg;
            end
        end
    end

    assign low_power_master_clock_o = lp_clk_reg;
    assign third_rate_clock_o       = third_clk_reg;
    assign slow_tick_clock_o        = slow_clk_reg;

    // ----------------------------------------------------------------
    // Central tick counter
    // ----------------------------------------------------------------
    logic [CW-1:0] ctick_reg;
    logic [3:0]    ctick_tap_reg;
    logic          ctick_inten_reg;
    logic          ctick_wake_reg;
    logic          ctick_int_reg;
    logic          ctick_wk_reg;

    wire logic ctick_run = !hibernate_i && !debug_halt_i;
    wire logic ctick_clr = wr_ct && wdata_i[ctsw_pkg::CT_CLR_BIT];
    wire logic ctick_adv = tick_1k && ctick_run && !ctick_clr;
    wire logic [CW-1:0] ctick_inc = ctick_reg + CW'(1);
    wire logic [CW:0] tap_one = (CW+1)'(1) << ctick_tap_reg;
    wire logic [CW-1:0] tap_mask = CW'(tap_one - (CW+1)'(1));
    wire logic ctick_evt = ctick_adv && ((ctick_inc & tap_mask) == '0);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctick_reg       <= '0;
            ctick_tap_reg   <= ctsw_pkg::CT_TAP_RST;
            ctick_inten_reg <= 1'b0;
            ctick_wake_reg  <= 1'b0;
            ctick_int_reg   <= 1'b0;
            ctick_wk_reg    <= 1'b0;
        end else begin
            if (ctick_clr) begin
                ctick_reg <= '0;
            end else if (ctick_adv) begin
                ctick_reg <= ctick_inc;
            end
            if (wr_ct) begin
                ctick_inten_reg <= wdata_i[ctsw_pkg::CT_INTEN_BIT];
                ctick_wake_reg  <= wdata_i[ctsw_pkg::CT_WAKE_BIT];
                ctick_tap_reg   <= wdata_i[ctsw_pkg::CT_TAP_LSB +: 4];
            end
            ctick_int_reg <= ctick_evt && ctick_inten_reg;
            ctick_wk_reg  <= ctick_evt && ctick_wake_reg;
        end
    end

    assign ctick_int_o  = ctick_int_reg;
    assign ctick_wake_o = ctick_wk_reg;

    // ----------------------------------------------------------------
    // Fast tick counter
    // ----------------------------------------------------------------
    logic [FW-1:0] ftick_reg;
    logic [FW-1:0] ftick_tc_reg;
    logic          ftick_inten_reg;
    logic          ftick_int_reg;

    // Compare with >= so a lowered terminal count never runs away
    wire logic ftick_term = (ftick_reg >= ftick_tc_reg);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ftick_reg       <= '0;
            ftick_tc_reg    <= ctsw_pkg::FT_TC_RST;
            ftick_inten_reg <= 1'b0;
            ftick_int_reg   <= 1'b0;
        end else begin
            if (tick_100k) begin
                ftick_reg <= ftick_term ? '0 : ftick_reg + FW'(1);
            end
            if (wr_ft) begin
                ftick_tc_reg    <= wdata_i[FW-1:0];
                ftick_inten_reg <= wdata_i[ctsw_pkg::FT_INTEN_BIT];
            end
            ftick_int_reg <= tick_100k && ftick_term && ftick_inten_reg;
        end
    end

    assign ftick_int_o = ftick_int_reg;

    // ----------------------------------------------------------------
    // Frequency synthesiser control
    // ----------------------------------------------------------------
    ctsw_pkg::ctsw_pll_cfg_type   pll_cfg_reg;
    ctsw_pkg::ctsw_pll_state_type pll_state_reg;
    ctsw_pkg::ctsw_pll_state_type pll_state_next;
    logic [LW-1:0]                pll_cnt_reg;

    wire ctsw_pkg::ctsw_pll_cfg_type pll_wcfg = wdata_i[14:0];
    wire logic pll_done = (pll_cnt_reg == LW'(PLL_LOCK_CYC - 1));

    // A config write with en set restarts acquisition; firmware turns it off
    // before low-power entry, which simply lands in the off state.
    always_comb begin
        pll_state_next = pll_state_reg;
        unique case (pll_state_reg)
            ctsw_pkg::PLL_OFF:    pll_state_next = pll_state_reg;
            ctsw_pkg::PLL_ACQ:    if (pll_done) pll_state_next = ctsw_pkg::PLL_LOCKED;
            ctsw_pkg::PLL_LOCKED: pll_state_next = pll_state_reg;
            default:              pll_state_next = ctsw_pkg::PLL_OFF;
        endcase
        if (wr_pll) begin
            pll_state_next = pll_wcfg.en ? ctsw_pkg::PLL_ACQ : ctsw_pkg::PLL_OFF;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pll_cfg_reg   <= '0;
            pll_state_reg <= ctsw_pkg::PLL_OFF;
            pll_cnt_reg   <= '0;
        end else begin
            if (wr_pll) begin
                pll_cfg_reg <= pll_wcfg;
            end
            pll_state_reg <= pll_state_next;
            if (wr_pll || pll_state_reg != ctsw_pkg::PLL_ACQ) begin
                pll_cnt_reg <= '0;
            end else if (!pll_done) begin
                pll_cnt_reg <= pll_cnt_reg + LW'(1);
            end
        end
    end

    assign pll_cfg_o       = pll_cfg_reg;
    assign pll_lock_o      = (pll_state_reg == ctsw_pkg::PLL_LOCKED);
    assign pll_out_valid_o = pll_lock_o;

    // ----------------------------------------------------------------
    // Doubler and main oscillator
    // ----------------------------------------------------------------
    logic       dbl_en_reg;
    logic [1:0] dbl_src_reg;
    logic [7:0] dbl_cnt_reg;
    logic [2:0] mo_freq_reg;
    logic       mo_usb_reg;
    logic [7:0] mo_trim_reg;

    wire logic dbl_rdy = (dbl_cnt_reg == 8'(ctsw_pkg::DBL_START_CYC));
    wire logic [2:0] mo_wfreq = (wdata_i[2:0] > 3'(ctsw_pkg::NUM_FREQ - 1))
                              ? 3'(ctsw_pkg::NUM_FREQ - 1) : wdata_i[2:0];
    wire logic trim_up = mo_usb_reg && usb_trim_up_i && (mo_trim_reg != 8'hFF);
    wire logic trim_dn = mo_usb_reg && usb_trim_dn_i && (mo_trim_reg != 8'h00);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dbl_en_reg  <= 1'b0;
            dbl_src_reg <= 2'h0;
            dbl_cnt_reg <= 8'h00;
            mo_freq_reg <= ctsw_pkg::MO_FREQ_RST;
            mo_usb_reg  <= 1'b0;
            mo_trim_reg <= ctsw_pkg::MAIN_TRIM[0];
        end else begin
            if (wr_dbl) begin
                dbl_en_reg  <= wdata_i[0];
                dbl_src_reg <= wdata_i[2:1];
            end
            if (wr_dbl || !dbl_en_reg) begin
                dbl_cnt_reg <= 8'h00;
            end else if (!dbl_rdy) begin
                dbl_cnt_reg <= dbl_cnt_reg + 8'h01;
            end
            if (wr_mo) begin
                mo_freq_reg <= mo_wfreq;
                mo_usb_reg  <= wdata_i[ctsw_pkg::MO_USB_BIT];
                mo_trim_reg <= ctsw_pkg::MAIN_TRIM[mo_wfreq];
            end else if (trim_up && !trim_dn) begin
                mo_trim_reg <= mo_trim_reg + 8'h01;
            end else if (trim_dn && !trim_up) begin
                mo_trim_reg <= mo_trim_reg - 8'h01;
            end
        end
    end

    assign dbl_en_o        = dbl_en_reg;
    assign dbl_src_o       = dbl_src_reg;
    assign dbl_ready_o     = dbl_en_reg && dbl_rdy;
    assign main_osc_freq_o = mo_freq_reg;
    assign main_osc_trim_o = mo_trim_reg;

    // ----------------------------------------------------------------
    // Watch crystal second tick
    // ----------------------------------------------------------------
    logic [14:0] watch_cnt_reg;
    logic        sleep_tick_reg;
    logic        rtc_sec_reg;

    wire logic watch_wrap = watch_tick_i && (watch_cnt_reg == 15'(ctsw_pkg::WATCH_DIV - 1));

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            watch_cnt_reg  <= 15'h0000;
            sleep_tick_reg <= 1'b0;
            rtc_sec_reg    <= 1'b0;
        end else begin
            if (watch_tick_i) begin
                watch_cnt_reg <= watch_cnt_reg + 15'h0001;
            end
            sleep_tick_reg <= watch_tick_i;
            rtc_sec_reg    <= watch_wrap;
        end
    end

    assign sleep_tick_o = sleep_tick_reg;
    assign rtc_sec_o    = rtc_sec_reg;

    // ----------------------------------------------------------------
    // Clock dividers
    // ----------------------------------------------------------------
    ctsw_pkg::ctsw_div_cfg_type div_cfg_reg [ctsw_pkg::NUM_DIV];
    logic [15:0]                div_rd      [ctsw_pkg::NUM_DIV];

    genvar gi;
    generate
        for (gi = 0; gi < ctsw_pkg::NUM_DIV; gi++) begin : g_div
            logic [15:0] cnt_reg;
            logic        clk_reg;
            wire logic   wr_d = wr_i && (addr_i == ctsw_pkg::ADR_DIV_BASE + 6'(gi));
            // CPU divider keeps only its low nibble; code 0 acts as 1
            wire logic [15:0] raw = (gi == ctsw_pkg::CPU_IDX)
                ? {12'h000, div_cfg_reg[gi].ratio[ctsw_pkg::CPU_DIV_W-1:0]}
                : div_cfg_reg[gi].ratio;
            wire logic [15:0] last = (raw == 16'h0000) ? 16'h0001 : raw;
            wire logic [16:0] half = (17'(last) + 17'h00001) >> 1;
            wire logic        stb  = src_tick_i[div_cfg_reg[gi].src];
            wire logic [15:0] nxt  = (cnt_reg >= last) ? 16'h0000 : cnt_reg + 16'h0001;

            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    div_cfg_reg[gi] <= '{src: 3'h0, ratio: ctsw_pkg::DIV_RATIO_RST};
                    cnt_reg         <= 16'h0000;
                    clk_reg         <= 1'b0;
                end else begin
                    if (wr_d) begin
                        div_cfg_reg[gi] <= wdata_i[18:0];
                    end
                    if (stb) begin
                        cnt_reg <= nxt;
                        clk_reg <= (17'(nxt) < half);
                    end
                end
            end

            assign div_clk_o[gi] = clk_reg;
            assign div_rd[gi]    = raw;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [ctsw_pkg::DW-1:0] rdata_next;
    logic [ctsw_pkg::DW-1:0] rdata_reg;

    wire logic [5:0] div_idx = addr_i - ctsw_pkg::ADR_DIV_BASE;
    wire logic div_hit = (addr_i >= ctsw_pkg::ADR_DIV_BASE)
                      && (div_idx < 6'(ctsw_pkg::NUM_DIV));

    always_comb begin
        rdata_next = '0;
        if (div_hit) begin
            rdata_next[15:0] = div_rd[4'(div_idx)];
            rdata_next[ctsw_pkg::DIV_SRC_LSB +: 3] = div_cfg_reg[4'(div_idx)].src;
        end else begin
            unique case (addr_i)
                ctsw_pkg::ADR_CTICK_CTRL: begin
                    rdata_next[ctsw_pkg::CT_INTEN_BIT]    = ctick_inten_reg;
                    rdata_next[ctsw_pkg::CT_WAKE_BIT]     = ctick_wake_reg;
                    rdata_next[ctsw_pkg::CT_TAP_LSB +: 4] = ctick_tap_reg;
                end
                ctsw_pkg::ADR_CTICK_CNT: rdata_next[CW-1:0] = ctick_reg;
                ctsw_pkg::ADR_FTICK: begin
                    rdata_next[FW-1:0]                     = ftick_tc_reg;
                    rdata_next[ctsw_pkg::FT_INTEN_BIT]     = ftick_inten_reg;
                    rdata_next[ctsw_pkg::FT_CNT_LSB +: FW] = ftick_reg;
                end
                ctsw_pkg::ADR_PLL: begin
                    rdata_next[14:0]                   = pll_cfg_reg;
                    rdata_next[ctsw_pkg::PLL_LOCK_BIT] = pll_lock_o;
                end
                ctsw_pkg::ADR_DBL: begin
                    rdata_next[2:0]                   = {dbl_src_reg, dbl_en_reg};
                    rdata_next[ctsw_pkg::DBL_RDY_BIT] = dbl_ready_o;
                end
                ctsw_pkg::ADR_MAIN_OSC: begin
                    rdata_next[2:0]                        = mo_freq_reg;
                    rdata_next[ctsw_pkg::MO_USB_BIT]       = mo_usb_reg;
                    rdata_next[ctsw_pkg::MO_TRIM_LSB +: 8] = mo_trim_reg;
                end
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rd_i ? rdata_next : '0;
        end
    end

    assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// file: verif/ctsw_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ctsw_asserts (
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    input wire logic [5:0]  addr_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        watch_tick_i,
    input wire logic        sleep_tick_o,
    input wire ctsw_pkg::ctsw_pll_cfg_type pll_cfg_o,
    input wire logic        pll_lock_o,
    input wire logic        pll_out_valid_o,
    input wire logic        ftick_int_o,
    input wire logic        low_power_master_clock_o,
    input wire logic [2:0]  main_osc_freq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    sequence pll_wr_s;
        wr_i && addr_i == ctsw_pkg::ADR_PLL;
    endsequence
    rd_slot_a: assert property (!$past(rd_i) |-> rdata_o == '0) else $error("read data outside slot");
    pll_restart_a: assert property (pll_wr_s |=> !pll_lock_o [*8]) else $error("lock too early");
    valid_lock_a: assert property (pll_out_valid_o |-> pll_lock_o) else $error("output valid unlocked");
    lock_en_a: assert property (pll_lock_o |-> pll_cfg_o.en) else $error("lock while off");
    ftick_pulse_a: assert property (ftick_int_o |=> !ftick_int_o) else $error("fast tick pulse long");
    sleep_tick_a: assert property (watch_tick_i |=> sleep_tick_o) else $error("sleep tick lost");
    lp_half_a: assert property ($changed(low_power_master_clock_o) |=> $stable(low_power_master_clock_o) [*3])
        else $error("low power clock half short");
    osc_range_a: assert property (main_osc_freq_o <= 3'h5) else $error("main osc step out of range");
endmodule
bind ctsw_top ctsw_asserts ctsw_asserts_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .watch_tick_i(watch_tick_i), .sleep_tick_o(sleep_tick_o),
    .pll_cfg_o(pll_cfg_o), .pll_lock_o(pll_lock_o), .pll_out_valid_o(pll_out_valid_o),
    .ftick_int_o(ftick_int_o), .low_power_master_clock_o(low_power_master_clock_o),
    .main_osc_freq_o(main_osc_freq_o));
`default_nettype wire

// file: verif/ctsw_partner.sv
`timescale 1ns/10ps
`default_nettype none
module ctsw_partner (
    input  wire logic       clk_i,
    output var  logic [7:0] src_tick_o = '0,
    output var  logic       watch_tick_o = 1'b0
);
    int unsigned cyc = 0;
    // Source i pulses every i+2 cycles, so dividers can tell their sources apart
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 8; i++) src_tick_o[i] <= (cyc % (i + 2)) == 0;
        watch_tick_o <= (cyc % 3) == 0;
    end
endmodule
`default_nettype wire

// file: verif/test_clock_source_and_timewheel.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module test_clock_source_and_timewheel;
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, hib = 1'b0, dbg = 1'b0, sel = 1'b0, fint, lock;
    logic [5:0]  addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [7:0]  src, trim;
    logic [2:0]  freq;
    logic [13:0] div;
    logic        wtick, third, tsel = 1'b0;
    int          errors = 0, tests_run = 0;
    int unsigned seed = 69618;
    wire probe = sel ? div[0] : (tsel ? third : fint);
    always #4 clk = ~clk;
    ctsw_partner ctsw_partner_i (.clk_i(clk), .src_tick_o(src), .watch_tick_o(wtick));
    ctsw_top #(.PLL_LOCK_CYC(20), .LS_HALF_CYC(4)) ctsw_top_i (.sys_clk_i(clk), .srst_i(srst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .hibernate_i(hib), .debug_halt_i(dbg),
        .src_tick_i(src), .usb_trim_up_i(1'b0), .usb_trim_dn_i(1'b0), .watch_tick_i(wtick),
        .slow_tick_clock_o(), .third_rate_clock_o(third), .low_power_master_clock_o(), .ctick_int_o(),
        .ctick_wake_o(), .ftick_int_o(fint), .pll_cfg_o(), .pll_lock_o(lock), .pll_out_valid_o(),
        .dbl_en_o(), .dbl_src_o(), .dbl_ready_o(), .main_osc_freq_o(freq), .main_osc_trim_o(trim),
        .sleep_tick_o(), .rtc_sec_o(), .div_clk_o(div));
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Rising edge to rising edge of the probe, in clock cycles
    task automatic per(output int n);
        time t0;
        @(posedge probe) t0 = $time;
        @(posedge probe) n = int'(($time - t0) / 8);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial begin
        logic [31:0] d, e;
        int n, k;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1 `CHK("trim", 8'h80, trim)
        for (int i = 0; i < 8; i++) begin
            k = i > 5 ? 5 : i;
            wr_reg(ctsw_pkg::ADR_MAIN_OSC, 32'(i));
            repeat (2) @(posedge clk);
            #1 `CHK("freq", 3'(k), freq)
            `CHK("trim", ctsw_pkg::MAIN_TRIM[k], trim)
        end
        for (int r = 0; r < 3; r++) begin
            e = {17'h0, 1'b1, 2'(r), 12'(xs())};
            wr_reg(ctsw_pkg::ADR_PLL, e);
            rd_reg(ctsw_pkg::ADR_PLL, d);
            `CHK("pll early", e, d)
            repeat (25) @(posedge clk);
            rd_reg(ctsw_pkg::ADR_PLL, d);
            `CHK("pll locked", e | 32'h10000, d)
        end
        // Synthesiser goes off before any halt below
        wr_reg(ctsw_pkg::ADR_PLL, 32'h0);
        #1 `CHK("lock off", 1'b0, lock)
        foreach (e[i]) if (i < 3) begin
            k = i == 0 ? 0 : (i == 1 ? 31 : int'(xs() % 32));
            wr_reg(ctsw_pkg::ADR_FTICK, 32'h100 | 32'(k));
            per(n);
            `CHK("ftick period", (k + 1) * 8, n)
        end
        // Third-rate clock: one period is six low-speed half periods of 4 cycles
        tsel <= 1'b1;
        per(n);
        `CHK("third period", ctsw_pkg::THIRD_HALVES * 2 * 4, n)
        // Doubler reports ready only after its start-up time
        wr_reg(ctsw_pkg::ADR_DBL, 32'h3);
        rd_reg(ctsw_pkg::ADR_DBL, d);
        `CHK("dbl early", 32'h3, d)
        repeat (ctsw_pkg::DBL_START_CYC + 4) @(posedge clk);
        rd_reg(ctsw_pkg::ADR_DBL, d);
        `CHK("dbl ready", 32'hB, d)
        sel <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            k = 1 + int'(xs() % 6);
            wr_reg(ctsw_pkg::ADR_DIV_BASE, {13'h0, 3'(s), 16'(k)});
            per(n);
            `CHK("div period", (k + 1) * (s + 2), n)
        end
        for (int h = 1; h < 3; h++) begin
            @(posedge clk) {dbg, hib} <= 2'(h);
            rd_reg(ctsw_pkg::ADR_CTICK_CNT, d);
            repeat (2000) @(posedge clk);
            rd_reg(ctsw_pkg::ADR_CTICK_CNT, e);
            `CHK("halted", d, e)
            wr_reg(ctsw_pkg::ADR_CTICK_CTRL, 32'h1);
            wr_reg(ctsw_pkg::ADR_CTICK_CNT, 32'h1FFF);
            rd_reg(ctsw_pkg::ADR_CTICK_CNT, d);
            `CHK("cleared", 32'h0, d)
            @(posedge clk) {dbg, hib} <= 2'h0;
            repeat (2000) @(posedge clk);
            rd_reg(ctsw_pkg::ADR_CTICK_CNT, d);
            `CHK("running", 1'b1, d inside {32'h2, 32'h3})
        end
        rd_reg(6'h3F, d);
        `CHK("unmapped", 32'h0, d)
        wrap_up();
    end
endmodule
`default_nettype wire
